/* bench/rtcc_core_bench.sv */
// Self-checking bench for the calendar, hold and alarm core
`timescale 1ns/1ps
`default_nettype none
module rtcc_core_bench;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic tick_1hz = 1'b0;
	logic scl;
	logic sda_h;
	logic ack;
	wire sda_oe;
	wire sda_out;
	wire int_n_oe;
	wire sda_w = sda_h & ~sda_oe;
	int failures = 0;
	int compares = 0;
	int cyc = 0;
	int i;
	int c;
	logic [31:0] lfsr_r = 32'h0000d2df;
	logic [7:0] v;
	logic [7:0] buf_a [0:7];
	logic [7:0] exp_a [0:7];
	always #20 ref_clk = ~ref_clk;
	rtcc_core rtcc_core_i (.ref_clk(ref_clk), .reset_n(reset_n), .tick_1hz(tick_1hz), .scl_in(scl),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .int_n_out(), .int_n_oe(int_n_oe));
	rtcc_host rtcc_host_i (.scl(scl), .sda_h(sda_h), .sda_w(sda_w));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		lfsr_next = {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
	endfunction
	// Readable bits of the registers 07h to 0Ch
	function automatic logic [7:0] msk(input logic [7:0] a);
		msk = (a == 8'h07) ? 8'h9f : (a == 8'h0c) ? 8'h87 : (a > 8'h09) ? 8'hbf : 8'hff;
	endfunction
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
	begin
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task chk_int(input logic e);
		chk("int", {7'h00, int_n_oe}, {7'h00, e});
	endtask
	task end_of_test;
	begin
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	// Write n bytes of buf_a from pointer p, one access
	task wr(input logic [7:0] p, input int n);
		int k;
	begin
		rtcc_host_i.start;
		rtcc_host_i.wbyte(8'ha2, ack);
		chk("ack", {7'h00, ack}, 8'h01);
		rtcc_host_i.wbyte(p, ack);
		for (k = 0; k < n; k++)
			rtcc_host_i.wbyte(buf_a[k], ack);
		rtcc_host_i.stop;
		repeat (8) @(posedge ref_clk);
	end
	endtask
	// Pointer, repeated start, then n bytes into buf_a
	task rd(input logic [7:0] p, input int n);
		int k;
	begin
		rtcc_host_i.start;
		rtcc_host_i.wbyte(8'ha2, ack);
		rtcc_host_i.wbyte(p, ack);
		rtcc_host_i.start;
		rtcc_host_i.wbyte(8'ha3, ack);
		for (k = 0; k < n; k++)
			rtcc_host_i.rbyte(k == n - 1, buf_a[k]);
		rtcc_host_i.stop;
	end
	endtask
	task tick;
	begin
		@(posedge ref_clk) tick_1hz <= 1'b1;
		@(posedge ref_clk) tick_1hz <= 1'b0;
		repeat (12) @(posedge ref_clk);
	end
	endtask
	// A hang counts as a mismatch
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			failures++;
			end_of_test;
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd(8'h07, 6);
		chk("cmon", buf_a[0], 8'h01);
		chk("year", buf_a[1], 8'h00);
		for (i = 2; i < 6; i++) chk("match", buf_a[i], 8'h80);
		rd(8'h01, 1);
		chk("flags", buf_a[0], 8'h00);
		$display("done reset values");
		// Random fields, first pass all ones to hit the unused bits
		for (c = 0; c < 4; c++)
		begin
			for (i = 0; i < 6; i++)
			begin
				lfsr_r = lfsr_next(lfsr_r);
				v = (c == 0) ? 8'hff : lfsr_r[7:0];
				buf_a[i] = v;
				exp_a[i] = v & msk(8'h07 + i[7:0]);
			end
			wr(8'h07, 6);
			rd(8'h07, 6);
			for (i = 0; i < 6; i++) chk("field", buf_a[i], exp_a[i]);
		end
		$display("done fields");
		// Last second of a year, both century values
		for (c = 0; c < 2; c++)
		begin
			buf_a = '{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, {c[0], 7'h12}, 8'h99, 8'h00};
			wr(8'h02, 7);
			tick;
			rd(8'h02, 7);
			chk("sec", buf_a[0], 8'h00);
			chk("cmon", buf_a[5], {~c[0], 7'h01});
			chk("year", buf_a[6], 8'h00);
		end
		$display("done rollover");
		// Two ticks inside one access: counters frozen, one step kept
		rtcc_host_i.start;
		rtcc_host_i.wbyte(8'ha2, ack);
		rtcc_host_i.wbyte(8'h02, ack);
		rtcc_host_i.wbyte(8'h10, ack);
		tick;
		tick;
		rd(8'h02, 1);
		chk("sec", buf_a[0], 8'h10);
		repeat (8) @(posedge ref_clk);
		rd(8'h02, 1);
		chk("sec", buf_a[0], 8'h11);
		$display("done hold");
		// Minute and day enabled; hour and weekday disabled with wrong values
		buf_a = '{8'h59, 8'h29, 8'h07, 8'h15, 8'h03, 8'h01, 8'h00, 8'h30};
		wr(8'h02, 8);
		buf_a = '{8'h88, 8'h15, 8'h85, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		wr(8'h0a, 3);
		buf_a[0] = 8'h02;
		wr(8'h01, 1);
		chk_int(1'b0);
		tick;
		chk_int(1'b1);
		rd(8'h01, 1);
		chk("flags", buf_a[0], 8'h0a);
		buf_a[0] = 8'h08;
		wr(8'h01, 1);
		chk_int(1'b0);
		buf_a[0] = 8'h0a;
		wr(8'h01, 1);
		chk_int(1'b1);
		buf_a[0] = 8'h02;
		wr(8'h01, 1);
		chk_int(1'b0);
		buf_a[0] = 8'h59;
		buf_a[1] = 8'h30;
		wr(8'h02, 2);
		tick;
		chk_int(1'b0);
		buf_a[1] = 8'h29;
		wr(8'h02, 2);
		tick;
		chk_int(1'b1);
		$display("done alarm");
		end_of_test;
	end
endmodule
bind rtcc_core rtcc_core_props rtcc_core_props_i (.ref_clk(ref_clk), .reset_n(reset_n), .tick_1hz(tick_1hz),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe));
`default_nettype wire

/* bench/rtcc_core_props.sv */
// Port checker for the calendar, hold and alarm core
`timescale 1ns/1ps
`default_nettype none
module rtcc_core_props
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic tick_1hz,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic int_n_out,
	input wire logic int_n_oe
);
	// ----------------------------------------
	// Quiet counters
	// ----------------------------------------
	logic [7:0] bus_q_r;
	logic [7:0] tick_q_r;
	logic [7:0] scl_hi_r;
	logic scl_d_r;
	logic sda_d_r;
	// Saturating counts since last pin change, last tick, and of SCL high
	always @(posedge ref_clk)
	begin
		scl_d_r <= scl_in;
		sda_d_r <= sda_in;
		bus_q_r <= (!reset_n || scl_in != scl_d_r || sda_in != sda_d_r) ? 8'h00 : bus_q_r + {7'h00, bus_q_r != 8'hff};
		tick_q_r <= (!reset_n || tick_1hz) ? 8'h00 : tick_q_r + {7'h00, tick_q_r != 8'hff};
		scl_hi_r <= !scl_in ? 8'h00 : scl_hi_r + {7'h00, scl_hi_r != 8'hff};
	end
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_rst_quiet;
		disable iff (1'b0) !reset_n |=> !sda_oe && !int_n_oe;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("pins active after reset");
	property p_pin_low;
		sda_out == 1'b0 && int_n_out == 1'b0;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("open drain level not low");
	// The flag only moves near a tick or bus traffic
	property p_int_quiet;
		bus_q_r > 8'h10 && tick_q_r > 8'h10 |-> $stable(int_n_oe);
	endproperty
	a_int_quiet: assert property (p_int_quiet) else $error("interrupt moved on its own");
	property p_int_cause;
		$rose(int_n_oe) && bus_q_r > 8'h28 |-> tick_q_r < 8'h08;
	endproperty
	a_int_cause: assert property (p_int_cause) else $error("interrupt without a step");
	property p_int_drop;
		$fell(int_n_oe) |-> bus_q_r < 8'h10;
	endproperty
	a_int_drop: assert property (p_int_drop) else $error("flag dropped without a write");
	// Data may only move while SCL is low, else it would fake a start or stop
	property p_oe_scl;
		$changed(sda_oe) |-> scl_hi_r < 8'h02;
	endproperty
	a_oe_scl: assert property (p_oe_scl) else $error("data moved with clock high");
	property p_oe_stands;
		$rose(sda_oe) |-> sda_oe [*4];
	endproperty
	a_oe_stands: assert property (p_oe_stands) else $error("data bit too short");
	property p_idle_free;
		bus_q_r > 8'h28 |-> !sda_oe;
	endproperty
	a_idle_free: assert property (p_idle_free) else $error("data held on idle bus");
endmodule
`default_nettype wire

/* bench/rtcc_host.sv */
// Serial host model for the clock and data pins
`timescale 1ns/1ps
`default_nettype none
module rtcc_host
(
	output logic scl,
	output logic sda_h,
	input wire logic sda_w
);
	logic r;
	// Idle bus: both lines released high
	initial
	begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	// One bit of 320 ns; read late in the high phase for margin on slow data
	task clk_bit(input logic b, output logic q);
	begin
		#80 sda_h <= b;
		#80 scl <= 1'b1;
		#140 q = sda_w;
		#20 scl <= 1'b0;
	end
	endtask
	// Works from idle and as a repeated start; pins move by non-blocking assignment after fixed 80 ns delays
	task start;
	begin
		#80 sda_h <= 1'b1;
		#80 scl <= 1'b1;
		#80 sda_h <= 1'b0;
		#80 scl <= 1'b0;
	end
	endtask
	// Each access is kept far shorter than one second
	task stop;
	begin
		#80 sda_h <= 1'b0;
		#80 scl <= 1'b1;
		#80 sda_h <= 1'b1;
		#160;
	end
	endtask
	task wbyte(input logic [7:0] b, output logic ack);
		integer i;
	begin
		for (i = 7; i >= 0; i--)
			clk_bit(b[i], r);
		clk_bit(1'b1, r);
		ack = !r;
	end
	endtask
	task rbyte(input logic nack, output logic [7:0] b);
		integer i;
	begin
		for (i = 7; i >= 0; i--)
			clk_bit(1'b1, b[i]);
		clk_bit(nack, r);
	end
	endtask
endmodule
`default_nettype wire

/* rtl/rtcc_core.v */
// Calendar upper registers, counter hold and alarm behind a serial slave
//
// Function
// - Century flag toggles whenever the year rolls from 99 to 00; resets to 0.
// - Century flag sits in bit 7 of the century and month register.
// - Month kept in BCD, tens in bit 4, units bits 3-0, 1 to 12.
// - Year register at 08h holds two BCD digits, tens 7-4, units 3-0.
// - Time counters 02h to 08h are held while a serial access runs.
// - On release, one increment that arrived during the access is applied.
// - Minute match register 09h: bit 7 disable, BCD minute below.
// - Hour match register 0Ah: bit 7 disable, bit 6 unused, BCD hour.
// - Day match register 0Bh: bit 7 disable, bit 6 unused, BCD day.
// - Weekday match register 0Ch: bit 7 disable, bits 6-3 unused, weekday 0-6.
// - Enabled fields compared with current time; all matching sets the alarm flag.
// - Fields with disable bit set take no part in matching.
// - Alarm flag stays until cleared; sets again only on a new matching advance.
// - With interrupt enable set, the interrupt pin follows the alarm flag.
// - Writes to the flag register AND the written value into the flags.
// - Alarm interrupt enable resets to 0.
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defs.vh"
module rtcc_core
(
	input wire ref_clk,
	input wire reset_n,
	input wire tick_1hz,
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output reg sda_oe,
	output wire int_n_out,
	output reg int_n_oe
);
	// ---------------------------------------------------------------
	// Serial slave states
	// ---------------------------------------------------------------
	localparam ST_IDLE = 3'd0;
	localparam ST_ADDR = 3'd1;
	localparam ST_ACKA = 3'd2;
	localparam ST_WR = 3'd3;
	localparam ST_ACKW = 3'd4;
	localparam ST_RD = 3'd5;
	localparam ST_RACK = 3'd6;

	reg [2:0] state_r;
	reg [3:0] bit_cnt_r;
	reg [7:0] shift_r;
	reg [7:0] ptr_r;
	reg read_r;
	reg first_r;
	reg nack_r;
	reg hold_r;
	reg pend_r;
	reg inc_done_r;
	reg [7:0] sec_r;
	reg [7:0] min_r;
	reg [7:0] hour_r;
	reg [7:0] day_r;
	reg [7:0] wday_r;
	reg [7:0] cmon_r;
	reg [7:0] year_r;
	reg [7:0] amin_r;
	reg [7:0] ahour_r;
	reg [7:0] aday_r;
	reg [7:0] awday_r;
	reg alarm_irq_enable;
	reg alarm_flag;
	wire scl_lvl;
	wire scl_rise;
	wire scl_fall;
	wire sda_lvl;
	wire sda_rise;
	wire sda_fall;
	wire start_det;
	wire stop_det;
	wire wr_strobe;
	wire do_inc;
	wire [7:0] view_w;
	wire [7:0] sec_step;
	wire [7:0] mon_step;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Next BCD value, wrapping from hi back to lo
	function [7:0] bcd_next;
		input [7:0] v;
		input [7:0] lo;
		input [7:0] hi;
		begin
			if (v == hi)
				bcd_next = lo;
			else if (v[3:0] == `RTCC_BCD_NINE)
				bcd_next = {v[7:4] + 4'h1, 4'h0};
			else
				bcd_next = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	// Last day of a month; leap years are those with the year divisible by four
	function [7:0] month_len;
		input [4:0] mon;
		input [7:0] yr;
		begin
			case (mon)
				5'h04, 5'h06, 5'h09, 5'h11: month_len = `RTCC_DAYS_30;
				`RTCC_MON_FEB: month_len = (yr[4] ? (yr[1:0] == 2'b10) : (yr[1:0] == 2'b00)) ?
					`RTCC_DAYS_29 : `RTCC_DAYS_28;
				default: month_len = `RTCC_DAYS_31;
			endcase
		end
	endfunction

	// Register read view; unused bits and unmapped pointers read zero
	function [7:0] reg_view;
		input [7:0] a;
		begin
			case (a)
				`RTCC_A_CTRL2: reg_view = {4'h0, alarm_flag, 1'b0, alarm_irq_enable, 1'b0};
				`RTCC_A_SEC: reg_view = sec_r & `RTCC_M_SEC;
				`RTCC_A_MIN: reg_view = min_r & `RTCC_M_MIN;
				`RTCC_A_HOUR: reg_view = hour_r & `RTCC_M_HOUR;
				`RTCC_A_DAY: reg_view = day_r & `RTCC_M_DAY;
				`RTCC_A_WDAY: reg_view = wday_r & `RTCC_M_WDAY;
				`RTCC_A_CMON: reg_view = cmon_r & `RTCC_M_CMON;
				`RTCC_A_YEAR: reg_view = year_r;
				`RTCC_A_AMIN: reg_view = amin_r & `RTCC_M_AMIN;
				`RTCC_A_AHOUR: reg_view = ahour_r & `RTCC_M_AHD;
				`RTCC_A_ADAY: reg_view = aday_r & `RTCC_M_AHD;
				`RTCC_A_AWDAY: reg_view = awday_r & `RTCC_M_AWDAY;
				default: reg_view = `RTCC_RST_ZERO;
			endcase
		end
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	rtcc_pin_sync u_scl_sync
	(
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pin_in(scl_in),
		.level(scl_lvl),
		.rise(scl_rise),
		.fall(scl_fall)
	);

	rtcc_pin_sync u_sda_sync
	(
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pin_in(sda_in),
		.level(sda_lvl),
		.rise(sda_rise),
		.fall(sda_fall)
	);

	// Both pins pass equal delay, so their relative order is kept
	assign start_det = sda_fall & scl_lvl;
	assign stop_det = sda_rise & scl_lvl;
	assign sda_out = 1'b0;
	assign int_n_out = 1'b0;
	// Host data byte complete: acknowledge goes out and the byte is used
	assign wr_strobe = (state_r == ST_WR) && scl_fall && (bit_cnt_r == 4'h8);
	// Function results named here, since a call cannot be part-selected
	assign view_w = reg_view(ptr_r);
	assign sec_step = bcd_next({1'b0, sec_r[6:0]}, 8'h00, `RTCC_MAX_SEC);
	assign mon_step = bcd_next({3'h0, cmon_r[4:0]}, 8'h01, `RTCC_MAX_MON);

	// ---------------------------------------------------------------
	// Serial slave state machine
	// ---------------------------------------------------------------
	// Data is sampled on SCL rise and driven after SCL fall
	always @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			state_r <= ST_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			ptr_r <= 8'h00;
			read_r <= 1'b0;
			first_r <= 1'b0;
			nack_r <= 1'b0;
			hold_r <= 1'b0;
			sda_oe <= 1'b0;
		end
		else if (stop_det)
		begin
			state_r <= ST_IDLE;
			hold_r <= 1'b0;
			sda_oe <= 1'b0;
		end
		else if (start_det)
		begin
			// A repeated start keeps the hold; only a stop ends it
			state_r <= ST_ADDR;
			bit_cnt_r <= 4'h0;
			sda_oe <= 1'b0;
		end
		else
		begin
			case (state_r)
				ST_ADDR, ST_WR:
				begin
					if (scl_rise && bit_cnt_r != 4'h8)
					begin
						shift_r <= {shift_r[6:0], sda_lvl};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
					else if (scl_fall && bit_cnt_r == 4'h8)
					begin
						if (state_r == ST_WR)
						begin
							sda_oe <= 1'b1;
							state_r <= ST_ACKW;
							first_r <= 1'b0;
							if (first_r)
								ptr_r <= shift_r;
							else
								ptr_r <= (ptr_r == `RTCC_A_LAST) ? 8'h00 : ptr_r + 8'h01;
						end
						else if (shift_r[7:1] == `RTCC_SLAVE_ADDR)
						begin
							sda_oe <= 1'b1;
							hold_r <= 1'b1;
							read_r <= shift_r[0];
							state_r <= ST_ACKA;
						end
						else
							state_r <= ST_IDLE;
					end
				end
				ST_ACKA, ST_ACKW, ST_RACK:
				begin
					if (state_r == ST_RACK && scl_rise)
						nack_r <= sda_lvl;
					if (scl_fall)
					begin
						bit_cnt_r <= 4'h0;
						if (state_r == ST_ACKW || (state_r == ST_ACKA && !read_r))
						begin
							sda_oe <= 1'b0;
							first_r <= (state_r == ST_ACKA);
							state_r <= ST_WR;
						end
						else if (state_r == ST_RACK && nack_r)
						begin
							sda_oe <= 1'b0;
							state_r <= ST_IDLE;
						end
						else
						begin
							// Next byte is taken from the frozen counters
							shift_r <= view_w;
							sda_oe <= ~view_w[7];
							ptr_r <= (ptr_r == `RTCC_A_LAST) ? 8'h00 : ptr_r + 8'h01;
							state_r <= ST_RD;
						end
					end
				end
				ST_RD:
				begin
					if (scl_fall)
					begin
						if (bit_cnt_r == 4'h7)
						begin
							sda_oe <= 1'b0;
							state_r <= ST_RACK;
						end
						else
						begin
							shift_r <= {shift_r[6:0], 1'b0};
							sda_oe <= ~shift_r[6];
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
					end
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Counter hold and pending tick
	// ---------------------------------------------------------------
	// Only one tick can wait; a second during the same hold is lost
	assign do_inc = ~hold_r & (tick_1hz | pend_r);

	always @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			pend_r <= 1'b0;
			inc_done_r <= 1'b0;
		end
		else
		begin
			if (hold_r && tick_1hz)
				pend_r <= 1'b1;
			else if (do_inc)
				pend_r <= 1'b0;
			inc_done_r <= do_inc;
		end
	end

	// ---------------------------------------------------------------
	// Time and date counters, alarm registers, flags
	// ---------------------------------------------------------------
	// Increment never meets a host write, since writes only occur under hold
	always @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			sec_r <= `RTCC_RST_SEC;
			min_r <= `RTCC_RST_ZERO;
			hour_r <= `RTCC_RST_ZERO;
			day_r <= `RTCC_RST_ONE;
			wday_r <= `RTCC_RST_ZERO;
			cmon_r <= `RTCC_RST_ONE;
			year_r <= `RTCC_RST_ZERO;
			amin_r <= `RTCC_RST_ALM;
			ahour_r <= `RTCC_RST_ALM;
			aday_r <= `RTCC_RST_ALM;
			awday_r <= `RTCC_RST_ALM;
			alarm_irq_enable <= 1'b0;
		end
		else if (do_inc)
		begin
			sec_r[6:0] <= sec_step[6:0];
			if (sec_r[6:0] == `RTCC_MAX_SEC)
			begin
				min_r <= bcd_next(min_r, 8'h00, `RTCC_MAX_SEC);
				if (min_r == `RTCC_MAX_SEC)
				begin
					hour_r <= bcd_next(hour_r, 8'h00, `RTCC_MAX_HOUR);
					if (hour_r == `RTCC_MAX_HOUR)
					begin
						wday_r <= bcd_next(wday_r, 8'h00, `RTCC_MAX_WDAY);
						day_r <= bcd_next(day_r, 8'h01, month_len(cmon_r[4:0], year_r));
						if (day_r == month_len(cmon_r[4:0], year_r))
						begin
							cmon_r[4:0] <= mon_step[4:0];
							if (cmon_r[4:0] == `RTCC_MAX_MON)
							begin
								year_r <= bcd_next(year_r, 8'h00, `RTCC_MAX_YEAR);
								if (year_r == `RTCC_MAX_YEAR)
									cmon_r[`RTCC_CENT_BIT] <= ~cmon_r[`RTCC_CENT_BIT];
							end
						end
					end
				end
			end
		end
		else if (wr_strobe && !first_r)
		begin
			case (ptr_r)
				`RTCC_A_CTRL2: alarm_irq_enable <= shift_r[`RTCC_AIE_BIT];
				`RTCC_A_SEC: sec_r <= shift_r;
				`RTCC_A_MIN: min_r <= shift_r;
				`RTCC_A_HOUR: hour_r <= shift_r;
				`RTCC_A_DAY: day_r <= shift_r;
				`RTCC_A_WDAY: wday_r <= shift_r;
				`RTCC_A_CMON: cmon_r <= shift_r & `RTCC_M_CMON;
				`RTCC_A_YEAR: year_r <= shift_r;
				`RTCC_A_AMIN: amin_r <= shift_r;
				`RTCC_A_AHOUR: ahour_r <= shift_r;
				`RTCC_A_ADAY: aday_r <= shift_r;
				`RTCC_A_AWDAY: awday_r <= shift_r;
				default: sec_r <= sec_r;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Alarm compare and flag
	// ---------------------------------------------------------------
	// Checked once per advance, so a lasting match re-raises a cleared flag only at the next advance
	wire min_ok = amin_r[`RTCC_DIS_BIT] | (amin_r[6:0] == min_r[6:0]);
	wire hour_ok = ahour_r[`RTCC_DIS_BIT] | (ahour_r[5:0] == hour_r[5:0]);
	wire day_ok = aday_r[`RTCC_DIS_BIT] | (aday_r[5:0] == day_r[5:0]);
	wire wday_ok = awday_r[`RTCC_DIS_BIT] | (awday_r[2:0] == wday_r[2:0]);
	// With every field disabled no alarm can occur
	wire any_on = ~(amin_r[`RTCC_DIS_BIT] & ahour_r[`RTCC_DIS_BIT] & aday_r[`RTCC_DIS_BIT] & awday_r[`RTCC_DIS_BIT]);
	wire alarm_hit = inc_done_r & any_on & min_ok & hour_ok & day_ok & wday_ok;

	always @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			alarm_flag <= 1'b0;
			int_n_oe <= 1'b0;
		end
		else
		begin
			// A new match wins over a clear in the same cycle
			if (alarm_hit)
				alarm_flag <= 1'b1;
			else if (wr_strobe && !first_r && ptr_r == `RTCC_A_CTRL2)
				alarm_flag <= alarm_flag & shift_r[`RTCC_AF_BIT];
			int_n_oe <= alarm_irq_enable & alarm_flag;
		end
	end
endmodule
`default_nettype wire

/* rtl/rtcc_defs.vh */
// Constants of the calendar, alarm and serial slave core
`ifndef RTCC_DEFS_VH
`define RTCC_DEFS_VH

// Serial slave address, 7 bits
`define RTCC_SLAVE_ADDR 7'h51

// Register pointer values
`define RTCC_A_CTRL2 8'h01
`define RTCC_A_SEC 8'h02
`define RTCC_A_MIN 8'h03
`define RTCC_A_HOUR 8'h04
`define RTCC_A_DAY 8'h05
`define RTCC_A_WDAY 8'h06
`define RTCC_A_CMON 8'h07
`define RTCC_A_YEAR 8'h08
`define RTCC_A_AMIN 8'h09
`define RTCC_A_AHOUR 8'h0a
`define RTCC_A_ADAY 8'h0b
`define RTCC_A_AWDAY 8'h0c
`define RTCC_A_LAST 8'h0f

// Field positions
`define RTCC_CENT_BIT 7
`define RTCC_DIS_BIT 7
`define RTCC_INTEG_BIT 7
`define RTCC_AF_BIT 3
`define RTCC_AIE_BIT 1

// Field masks of the readable bits
`define RTCC_M_SEC 8'hff
`define RTCC_M_MIN 8'h7f
`define RTCC_M_HOUR 8'h3f
`define RTCC_M_DAY 8'h3f
`define RTCC_M_WDAY 8'h07
`define RTCC_M_CMON 8'h9f
`define RTCC_M_AMIN 8'hff
`define RTCC_M_AHD 8'hbf
`define RTCC_M_AWDAY 8'h87

// Reset values
`define RTCC_RST_SEC 8'h80
`define RTCC_RST_ZERO 8'h00
`define RTCC_RST_ONE 8'h01
`define RTCC_RST_ALM 8'h80

// Counting limits in BCD
`define RTCC_MAX_SEC 8'h59
`define RTCC_MAX_HOUR 8'h23
`define RTCC_MAX_MON 8'h12
`define RTCC_MAX_YEAR 8'h99
`define RTCC_MAX_WDAY 8'h06
`define RTCC_DAYS_28 8'h28
`define RTCC_DAYS_29 8'h29
`define RTCC_DAYS_30 8'h30
`define RTCC_DAYS_31 8'h31
`define RTCC_MON_FEB 5'h02
`define RTCC_BCD_NINE 4'h9

`endif

/* rtl/rtcc_pin_sync.v */
// Two-flop synchroniser with edge detection for one pin
`timescale 1ns/1ps
`default_nettype none
module rtcc_pin_sync
(
	input wire ref_clk,
	input wire reset_n,
	input wire pin_in,
	output wire level,
	output wire rise,
	output wire fall
);
	reg meta_r;
	reg sync_r;
	reg last_r;

	// Pins idle high; only sync_r and last_r feed the edge logic
	always @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			last_r <= 1'b1;
		end
		else
		begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	// Edge pulses, one cycle each
	assign level = sync_r;
	assign rise = sync_r & ~last_r;
	assign fall = ~sync_r & last_r;
endmodule
`default_nettype wire
